// ### inc/mta_pkg.sv
// Register map, field positions and timing constants of the side-band pin block
package mta_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CMD = 8'h04;
    localparam logic [7:0] ADDR_ALARM_CFG = 8'h08;
    localparam logic [7:0] ADDR_FAST_CFG = 8'h0c;
    localparam logic [7:0] ADDR_ALERT_MASK = 8'h10;
    localparam logic [7:0] ADDR_PIN_STAT = 8'h14;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h1c;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h20;
    // Control register fields
    localparam int CTRL_TRIG_MODE = 0;
    localparam int CTRL_GPIO_DIR = 1;
    localparam int CTRL_GPIO_OUT = 2;
    // Command register fields
    localparam int CMD_TRIG = 0;
    localparam int CMD_ALARM_CLR = 1;
    // Alarm index within 3-bit groups
    localparam int AL_FAST = 0;
    localparam int AL_UPPER = 1;
    localparam int AL_LOWER = 2;
    // Alarm config: enables [2:0], latch selects [6:4]
    localparam int ALCFG_EN_LSB = 0;
    localparam int ALCFG_LATCH_LSB = 4;
    // Fast config: filter [7:0], lower-limit delay [15:8]
    localparam int FCFG_FILT_LSB = 0;
    localparam int FCFG_DLY_LSB = 8;
    // Alert mask: alarm masks [2:0], alert enable bit 7
    localparam int AMASK_EN = 7;
    // Interrupt status bits
    localparam int IRQ_CONV = 0;
    localparam int IRQ_SHORT = 1;
    localparam int IRQ_FAST = 2;
    localparam int IRQ_UPPER = 3;
    localparam int IRQ_LOWER = 4;
    localparam int IRQ_W = 5;
    // Reset values
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [6:0] ALCFG_RST = 7'h00;
    localparam logic [15:0] FCFG_RST = 16'h0000;
    localparam logic [7:0] AMASK_RST = 8'h00;
    localparam logic [IRQ_W-1:0] IRQ_RST = 5'h00;
    // Timing
    localparam int CLK_NS = 50;
    localparam int TRIG_LOW_NS = 4000;
    localparam int TRIG_LOW_CYC = (TRIG_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYC = TICK_NS / CLK_NS;
    // Synchronised pin vector positions
    localparam int SY_CONV = 0;
    localparam int SY_GPIO = 1;
    localparam int SY_FAST = 2;
    localparam int SY_UPPER = 3;
    localparam int SY_LOWER = 4;
    localparam int SY_W = 5;
endpackage : mta_pkg

// ### hw/mta_side_pins.sv
// Trigger, general-purpose pin, alarm and alert pin logic with APB registers
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/100ps
// Overview of operation
// R1: Trigger falling edge starts conversion in triggered mode
// R2: Host holds trigger low at least 4 us
// R3: Trigger held low: each command starts conversion in triggered mode
// R4: General pin resets input; output is push-pull
// R5: Fast alarm open-drain, off, transparent, filtered
// R6: Upper alarm open-drain, off, transparent by default
// R7: Lower alarm open-drain, off, transparent, delayed
// R8: Alert open-drain, off, governed by mask
module mta_side_pins import mta_pkg::*; (
    input wire logic clk_sys,
    input wire logic reset_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Conversion trigger pin
    input wire logic convertPin_n,
    output logic convStart,
    // General-purpose pin
    input wire logic gpioIn,
    output logic gpioOut,
    output logic gpioOe,
    // Comparator results
    input wire logic fastCmp,
    input wire logic upperCmp,
    input wire logic lowerCmp,
    // Open-drain alarm pins
    input wire logic fastAlarmIn,
    output logic fastAlarmOut,
    output logic fastAlarmOe,
    input wire logic upperAlarmIn,
    output logic upperAlarmOut,
    output logic upperAlarmOe,
    input wire logic lowerAlarmIn,
    output logic lowerAlarmOut,
    output logic lowerAlarmOe,
    input wire logic alertIn,
    output logic alertOut,
    output logic alertOe,
    // Interrupt
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [SY_W-1:0] syncA_reg; // First sync stage
    logic [SY_W-1:0] syncB_reg; // Second sync stage
    logic [3:0] pinA_reg; // Pin readback first stage
    logic [3:0] pinB_reg; // Pin readback second stage
    logic convPrev_reg; // Trigger level one cycle ago
    logic [7:0] lowCnt_reg; // Trigger low-time counter
    logic [2:0] ctrl_reg; // Control register
    logic [6:0] alCfg_reg; // Alarm enables and latches
    logic [15:0] fCfg_reg; // Filter and delay
    logic [7:0] aMask_reg; // Alert mask
    logic [IRQ_W-1:0] irqStat_reg; // Sticky events
    logic [IRQ_W-1:0] irqEn_reg; // Interrupt enables
    logic [4:0] tickCnt_reg; // Microsecond prescaler
    logic tick; // One-cycle us enable
    logic [7:0] fastCnt_reg; // Fast filter counter
    logic [7:0] lowDly_reg; // Lower delay counter
    logic [2:0] raw; // Qualified comparisons
    logic [2:0] held_reg; // Latched alarms
    logic [2:0] alarm_reg; // Alarm pin states
    logic alert_reg; // Alert pin state
    logic convStart_reg; // Conversion start pulse
    logic [2:0] rawPrev_reg; // For rising-edge events
    logic wrEn; // Write access phase
    logic setupRd; // Read setup phase
    logic cmdTrig; // Trigger command strobe
    logic cmdClr; // Alarm clear strobe
    logic trigEdge; // Trigger falling edge
    logic shortLow; // Trigger released too early
    logic [IRQ_W-1:0] irqSet; // Events this cycle
    logic [IRQ_W-1:0] irqClr; // Clears this cycle
    logic known; // Address is mapped
    logic [31:0] rdMux; // Read data mux

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    // Two flops on every pin input
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            // Trigger and pin idle high, comparators idle low
            syncA_reg <= 5'h03;
            syncB_reg <= 5'h03;
        end else begin
            syncA_reg <= {lowerCmp, upperCmp, fastCmp, gpioIn, convertPin_n};
            syncB_reg <= syncA_reg;
        end
    end

    // Readback of open-drain pin levels
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pinA_reg <= 4'hf;
            pinB_reg <= 4'hf;
        end else begin
            pinA_reg <= {alertIn, lowerAlarmIn, upperAlarmIn, fastAlarmIn};
            pinB_reg <= pinA_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB decode

    assign wrEn = psel && penable && pwrite;
    assign setupRd = psel && !penable && !pwrite;
    assign cmdTrig = wrEn && (paddr == ADDR_CMD) && pwdata[CMD_TRIG];
    assign cmdClr = wrEn && (paddr == ADDR_CMD) && pwdata[CMD_ALARM_CLR];
    assign pready = 1'b1;

    // Mapped address check
    always_comb begin
        if (paddr == ADDR_CTRL || paddr == ADDR_CMD) begin
            known = 1'b1;
        end else if (paddr == ADDR_ALARM_CFG || paddr == ADDR_FAST_CFG) begin
            known = 1'b1;
        end else if (paddr == ADDR_ALERT_MASK || paddr == ADDR_PIN_STAT) begin
            known = 1'b1;
        end else if (paddr == ADDR_IRQ_STAT || paddr == ADDR_IRQ_CLR) begin
            known = 1'b1;
        end else if (paddr == ADDR_IRQ_EN) begin
            known = 1'b1;
        end else begin
            known = 1'b0;
        end
    end

    assign pslverr = psel && penable && !known;

    // Read data selection
    always_comb begin
        rdMux = 32'h0;
        if (paddr == ADDR_CTRL) begin
            rdMux[2:0] = ctrl_reg;
        end else if (paddr == ADDR_ALARM_CFG) begin
            rdMux[6:0] = alCfg_reg;
        end else if (paddr == ADDR_FAST_CFG) begin
            rdMux[15:0] = fCfg_reg;
        end else if (paddr == ADDR_ALERT_MASK) begin
            rdMux[7:0] = aMask_reg;
        end else if (paddr == ADDR_PIN_STAT) begin
            // Pin levels and alarm states
            rdMux[1:0] = {syncB_reg[SY_GPIO], syncB_reg[SY_CONV]};
            rdMux[7:4] = pinB_reg;
            rdMux[10:8] = alarm_reg;
            rdMux[11] = alert_reg;
        end else if (paddr == ADDR_IRQ_STAT) begin
            rdMux[IRQ_W-1:0] = irqStat_reg;
        end else if (paddr == ADDR_IRQ_EN) begin
            rdMux[IRQ_W-1:0] = irqEn_reg;
        end else begin
            rdMux = 32'h0;
        end
    end

    // Read data captured in setup phase
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= 32'h0;
        end else if (setupRd) begin
            prdata <= rdMux;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers

    // Writable registers
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_reg <= CTRL_RST;
            alCfg_reg <= ALCFG_RST;
            fCfg_reg <= FCFG_RST;
            aMask_reg <= AMASK_RST;
            irqEn_reg <= IRQ_RST;
        end else if (wrEn) begin
            if (paddr == ADDR_CTRL) begin
                ctrl_reg <= pwdata[2:0];
            end else if (paddr == ADDR_ALARM_CFG) begin
                alCfg_reg <= pwdata[6:0];
            end else if (paddr == ADDR_FAST_CFG) begin
                fCfg_reg <= pwdata[15:0];
            end else if (paddr == ADDR_ALERT_MASK) begin
                aMask_reg <= pwdata[7:0];
            end else if (paddr == ADDR_IRQ_EN) begin
                irqEn_reg <= pwdata[IRQ_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Conversion trigger

    assign trigEdge = convPrev_reg && !syncB_reg[SY_CONV];
    // R2: release before minimum low time
    assign shortLow = !convPrev_reg && syncB_reg[SY_CONV]
        && (lowCnt_reg < 8'(TRIG_LOW_CYC));

    // Previous trigger level
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            convPrev_reg <= 1'b1;
        end else begin
            convPrev_reg <= syncB_reg[SY_CONV];
        end
    end

    // R2: measure trigger low time
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            lowCnt_reg <= 8'h00;
        end else if (syncB_reg[SY_CONV]) begin
            lowCnt_reg <= 8'h00;
        end else if (lowCnt_reg != 8'hff) begin
            lowCnt_reg <= lowCnt_reg + 8'h01;
        end
    end

    // Start pulse generation
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            convStart_reg <= 1'b0;
        end else if (ctrl_reg[CTRL_TRIG_MODE]) begin
            // R1: falling edge starts conversion
            // R3: command while held low
            convStart_reg <= trigEdge || (cmdTrig && !syncB_reg[SY_CONV]);
        end else begin
            convStart_reg <= 1'b0;
        end
    end

    assign convStart = convStart_reg;

    ////////////////////////////////////////////////////////////////////////////
    // General-purpose pin

    // R4: input at reset, push-pull when output
    assign gpioOe = ctrl_reg[CTRL_GPIO_DIR];
    assign gpioOut = ctrl_reg[CTRL_GPIO_OUT];

    ////////////////////////////////////////////////////////////////////////////
    // Alarm qualification

    // Microsecond enable divider
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            tickCnt_reg <= 5'h00;
        end else if (tickCnt_reg == 5'(TICK_CYC - 1)) begin
            tickCnt_reg <= 5'h00;
        end else begin
            tickCnt_reg <= tickCnt_reg + 5'h01;
        end
    end

    assign tick = (tickCnt_reg == 5'(TICK_CYC - 1));

    // R5: fast filter, consecutive cycles
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            fastCnt_reg <= 8'h00;
        end else if (!syncB_reg[SY_FAST]) begin
            fastCnt_reg <= 8'h00;
        end else if (fastCnt_reg != 8'hff) begin
            fastCnt_reg <= fastCnt_reg + 8'h01;
        end
    end

    // R7: lower delay, microsecond steps
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            lowDly_reg <= 8'h00;
        end else if (!syncB_reg[SY_LOWER]) begin
            lowDly_reg <= 8'h00;
        end else if (tick && lowDly_reg != 8'hff) begin
            lowDly_reg <= lowDly_reg + 8'h01;
        end
    end

    // Qualified comparisons
    always_comb begin
        raw[AL_FAST] = syncB_reg[SY_FAST]
            && (fastCnt_reg >= fCfg_reg[FCFG_FILT_LSB +: 8]);
        // R6: upper follows comparison directly
        raw[AL_UPPER] = syncB_reg[SY_UPPER];
        raw[AL_LOWER] = syncB_reg[SY_LOWER]
            && (lowDly_reg >= fCfg_reg[FCFG_DLY_LSB +: 8]);
    end

    // Latched copies, set wins over clear
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            held_reg <= 3'h0;
        end else begin
            held_reg <= raw | (held_reg & {3{!cmdClr}});
        end
    end

    // R5: R6: R7: enable and latch select
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            alarm_reg <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                alarm_reg[i] <= alCfg_reg[ALCFG_EN_LSB + i]
                    && (alCfg_reg[ALCFG_LATCH_LSB + i] ? held_reg[i] : raw[i]);
            end
        end
    end

    // R8: alert from masked alarms
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            alert_reg <= 1'b0;
        end else begin
            alert_reg <= aMask_reg[AMASK_EN] && |(aMask_reg[2:0] & alarm_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Open-drain pin drive

    // R5: fast pin pulls low when active
    assign fastAlarmOut = 1'b0;
    assign fastAlarmOe = alarm_reg[AL_FAST];
    // R6: upper pin pulls low when active
    assign upperAlarmOut = 1'b0;
    assign upperAlarmOe = alarm_reg[AL_UPPER];
    // R7: lower pin pulls low when active
    assign lowerAlarmOut = 1'b0;
    assign lowerAlarmOe = alarm_reg[AL_LOWER];
    // R8: alert pin pulls low when active
    assign alertOut = 1'b0;
    assign alertOe = alert_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Interrupts

    // Rising edge of alarm states
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rawPrev_reg <= 3'h0;
        end else begin
            rawPrev_reg <= alarm_reg;
        end
    end

    assign irqSet = {alarm_reg & ~rawPrev_reg, shortLow, convStart_reg};
    assign irqClr = (wrEn && paddr == ADDR_IRQ_CLR) ? pwdata[IRQ_W-1:0] : IRQ_RST;

    // Sticky status, set wins over clear
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            irqStat_reg <= IRQ_RST;
        end else begin
            irqStat_reg <= irqSet | (irqStat_reg & ~irqClr);
        end
    end

    assign irq = |(irqStat_reg & irqEn_reg);

endmodule : mta_side_pins

// ### dv/mta_side_pins_chk.sv
// Assertion checker for the side-band pin block
`timescale 1ns/100ps
module mta_side_pins_chk import mta_pkg::*; (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic convertPin_n,
    input wire logic convStart,
    input wire logic gpioOut,
    input wire logic gpioOe,
    input wire logic fastCmp,
    input wire logic upperCmp,
    input wire logic lowerCmp,
    input wire logic fastAlarmOe,
    input wire logic upperAlarmOe,
    input wire logic lowerAlarmOe,
    input wire logic alertOe
);
    ////////////////////////////////////////
    // Completed write on the bus
    logic wrDone;
    logic [2:0] ctrl_reg; // Shadow of control fields
    logic [2:0] alCfg_reg; // Shadow of alarm enables
    logic alertEn_reg; // Shadow of alert enable
    assign wrDone = psel & penable & pwrite & pready;
    // Shadow copies follow completed writes
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_reg <= CTRL_RST;
            alCfg_reg <= ALCFG_RST[2:0];
            alertEn_reg <= AMASK_RST[AMASK_EN];
        end else if (wrDone) begin
            if (paddr == ADDR_CTRL) ctrl_reg <= pwdata[2:0];
            if (paddr == ADDR_ALARM_CFG) alCfg_reg <= pwdata[2:0];
            if (paddr == ADDR_ALERT_MASK) alertEn_reg <= pwdata[AMASK_EN];
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    AST_EDGE_START: assert property (
        ctrl_reg[CTRL_TRIG_MODE] && $fell(convertPin_n) ##1 !convertPin_n [*2] |=> convStart)
        else $error("no start after trigger edge");
    AST_CMD_START: assert property (
        (ctrl_reg[CTRL_TRIG_MODE] && !convertPin_n) [*4] ##0
        (wrDone && paddr == ADDR_CMD && pwdata[CMD_TRIG]) |-> ##[1:2] convStart)
        else $error("no start after command");
    AST_MODE_ONLY: assert property (
        convStart |-> !$past(convertPin_n, 3) && $past(ctrl_reg[CTRL_TRIG_MODE], 1))
        else $error("start without mode or low pin");
    AST_GPIO_DIR: assert property (gpioOe == ctrl_reg[CTRL_GPIO_DIR])
        else $error("pin direction wrong");
    AST_GPIO_DRIVE: assert property (gpioOe |-> gpioOut == ctrl_reg[CTRL_GPIO_OUT])
        else $error("pin level wrong");
    AST_FAST_FOLLOW: assert property (!fastCmp [*5] |-> !fastAlarmOe)
        else $error("fast alarm stuck");
    AST_UPPER_SET: assert property (alCfg_reg[AL_UPPER] && upperCmp [*4] |-> upperAlarmOe)
        else $error("upper alarm late");
    AST_UPPER_OFF: assert property (!alCfg_reg[AL_UPPER] [*3] |-> !upperAlarmOe)
        else $error("upper alarm while disabled");
    AST_LOWER_FOLLOW: assert property (!lowerCmp [*5] |-> !lowerAlarmOe)
        else $error("lower alarm stuck");
    AST_ALERT_OFF: assert property (!alertEn_reg [*3] |-> !alertOe)
        else $error("alert while disabled");
endmodule : mta_side_pins_chk
bind mta_side_pins mta_side_pins_chk u_chk (.clk_sys(clk_sys), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .convertPin_n(convertPin_n), .convStart(convStart), .gpioOut(gpioOut),
    .gpioOe(gpioOe), .fastCmp(fastCmp), .upperCmp(upperCmp), .lowerCmp(lowerCmp),
    .fastAlarmOe(fastAlarmOe), .upperAlarmOe(upperAlarmOe), .lowerAlarmOe(lowerAlarmOe),
    .alertOe(alertOe));

// ### dv/mta_host_model.sv
// Host-side model: trigger driver, general pin level, pulled-up alarm wires
`timescale 1ns/100ps
module mta_host_model (
    input wire logic clk_sys,
    output logic convertPin_n,
    input wire logic gpioOut,
    input wire logic gpioOe,
    output logic gpioIn,
    input wire logic fastAlarmOe,
    input wire logic upperAlarmOe,
    input wire logic lowerAlarmOe,
    input wire logic alertOe,
    output logic fastAlarmIn,
    output logic upperAlarmIn,
    output logic lowerAlarmIn,
    output logic alertIn
);
    logic hostGpio = 1'b0; // Host level while the block listens
    // Trigger idles high
    initial convertPin_n = 1'b1;
    // Shared pin: block wins while it drives
    assign gpioIn = gpioOe ? gpioOut : hostGpio;
    // Pull-ups: wire low while the block pulls
    assign fastAlarmIn = ~fastAlarmOe;
    assign upperAlarmIn = ~upperAlarmOe;
    assign lowerAlarmIn = ~lowerAlarmOe;
    assign alertIn = ~alertOe;
    // Set trigger level at once, without waiting for an edge
    task automatic trigLevel(input logic v);
        convertPin_n <= v;
    endtask : trigLevel
    // low pulse, short only when asked
    task automatic trigPulse(input int lowCyc);
        trigLevel(1'b0);
        repeat (lowCyc) @(posedge clk_sys);
        trigLevel(1'b1);
    endtask : trigPulse
endmodule : mta_host_model

// ### dv/mta_side_pins_tb.sv
// Self-checking testbench of the side-band pin block
`timescale 1ns/100ps
`define CHK(what, exp, got) begin cmpCount++; if ((got) !== (exp)) begin failCount++; \
    $display("[FAIL] %s expected %h seen %h", what, exp, got); end end
module mta_side_pins_tb import mta_pkg::*; ;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, convertPin_n, convStart, gpioIn, gpioOut, gpioOe, irq;
    logic fastCmp = 1'b0, upperCmp = 1'b0, lowerCmp = 1'b0;
    logic fastAlarmIn, fastAlarmOut, fastAlarmOe, upperAlarmIn, upperAlarmOut, upperAlarmOe;
    logic lowerAlarmIn, lowerAlarmOut, lowerAlarmOe, alertIn, alertOut, alertOe;
    int failCount = 0, cmpCount = 0, convCnt = 0, cycles = 0;
    // Clock of 50 ns
    always #(CLK_NS / 2) clk_sys = ~clk_sys;
    mta_side_pins u_mta_side_pins (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .convertPin_n(convertPin_n),
        .convStart(convStart), .gpioIn(gpioIn), .gpioOut(gpioOut), .gpioOe(gpioOe),
        .fastCmp(fastCmp), .upperCmp(upperCmp), .lowerCmp(lowerCmp),
        .fastAlarmIn(fastAlarmIn), .fastAlarmOut(fastAlarmOut), .fastAlarmOe(fastAlarmOe),
        .upperAlarmIn(upperAlarmIn), .upperAlarmOut(upperAlarmOut),
        .upperAlarmOe(upperAlarmOe), .lowerAlarmIn(lowerAlarmIn),
        .lowerAlarmOut(lowerAlarmOut), .lowerAlarmOe(lowerAlarmOe), .alertIn(alertIn),
        .alertOut(alertOut), .alertOe(alertOe), .irq(irq));
    mta_host_model u_mta_host_model (.clk_sys(clk_sys), .convertPin_n(convertPin_n),
        .gpioOut(gpioOut), .gpioOe(gpioOe), .gpioIn(gpioIn), .fastAlarmOe(fastAlarmOe),
        .upperAlarmOe(upperAlarmOe), .lowerAlarmOe(lowerAlarmOe), .alertOe(alertOe),
        .fastAlarmIn(fastAlarmIn), .upperAlarmIn(upperAlarmIn),
        .lowerAlarmIn(lowerAlarmIn), .alertIn(alertIn));
    ////////////////////////////////////////
    // Count start pulses, cut a hang short
    always @(posedge clk_sys) begin
        cycles++;
        if (convStart === 1'b1) convCnt++;
        if (cycles == 5000) begin
            failCount++;
            conclude();
        end
    end
    // Counts and verdict
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmpCount, failCount);
        if (failCount == 0 && cmpCount > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : conclude
    // One bus transfer, then one idle cycle
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb
    // Read and compare
    task automatic chkRd(input logic [7:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        `CHK(what, exp, rd)
    endtask : chkRd
    ////////////////////////////////////////
    // Reset state and refused address
    task automatic testResets();
        logic [7:0] adr [6] = '{ADDR_CTRL, ADDR_ALARM_CFG, ADDR_FAST_CFG, ADDR_ALERT_MASK,
            ADDR_IRQ_STAT, ADDR_IRQ_EN};
        for (int i = 0; i < 6; i++) chkRd(adr[i], 32'h0, "reset value");
        `CHK("pins off", 5'h0, {gpioOe, fastAlarmOe, upperAlarmOe, lowerAlarmOe, alertOe})
        apb(1'b0, 8'h24, 32'h0);
        `CHK("unmapped error", 1'b1, err)
        $display("test resets done");
    endtask : testResets
    // Edge start, mode off, short low, interrupt
    task automatic testTrigger();
        int c = convCnt;
        apb(1'b1, ADDR_IRQ_EN, 32'h1);
        u_mta_host_model.trigPulse(TRIG_LOW_CYC);
        repeat (8) @(posedge clk_sys);
        `CHK("no start in free mode", c, convCnt)
        apb(1'b1, ADDR_CTRL, 32'h1);
        u_mta_host_model.trigPulse(TRIG_LOW_CYC);
        repeat (8) @(posedge clk_sys);
        `CHK("start count", c + 1, convCnt)
        `CHK("irq raised", 1'b1, irq)
        chkRd(ADDR_IRQ_STAT, 32'h1, "start flag");
        apb(1'b1, ADDR_IRQ_EN, 32'h0);
        `CHK("irq masked", 1'b0, irq)
        apb(1'b1, ADDR_IRQ_CLR, 32'h1);
        chkRd(ADDR_IRQ_STAT, 32'h0, "flag cleared");
        u_mta_host_model.trigPulse(10);
        repeat (8) @(posedge clk_sys);
        chkRd(ADDR_IRQ_STAT, 32'h3, "short low flag");
        apb(1'b1, ADDR_IRQ_CLR, 32'h3);
        $display("test trigger done");
    endtask : testTrigger
    // Commands while the pin stays low
    task automatic testCmd();
        int c = convCnt;
        u_mta_host_model.trigLevel(1'b0);
        repeat (8) @(posedge clk_sys);
        for (int i = 0; i < 3; i++) apb(1'b1, ADDR_CMD, 32'h1);
        repeat (4) @(posedge clk_sys);
        `CHK("command starts", c + 4, convCnt)
        u_mta_host_model.trigLevel(1'b1);
        $display("test command done");
    endtask : testCmd
    // General pin input then push-pull
    task automatic testGpio();
        u_mta_host_model.hostGpio <= 1'b1;
        repeat (4) @(posedge clk_sys);
        apb(1'b0, ADDR_PIN_STAT, 32'h0);
        `CHK("pin read", 2'b01, {gpioOe, rd[1]})
        u_mta_host_model.hostGpio <= 1'b0;
        apb(1'b1, ADDR_CTRL, 32'h6);
        `CHK("drive high", 2'b11, {gpioOe, gpioIn})
        apb(1'b1, ADDR_CTRL, 32'h2);
        `CHK("drive low", 2'b10, {gpioOe, gpioIn})
        apb(1'b1, ADDR_CTRL, 32'h0);
        $display("test gpio done");
    endtask : testGpio
    // Filter 20 cycles, lower delay 2 ticks
    task automatic testAlarms();
        apb(1'b1, ADDR_FAST_CFG, 32'h0214);
        {fastCmp, upperCmp, lowerCmp} <= 3'h7;
        repeat (8) @(posedge clk_sys);
        `CHK("disabled", 3'h0, {fastAlarmOe, upperAlarmOe, lowerAlarmOe})
        apb(1'b1, ADDR_ALARM_CFG, 32'h7);
        repeat (4) @(posedge clk_sys);
        `CHK("early", 3'b010, {fastAlarmOe, upperAlarmOe, lowerAlarmOe})
        repeat (60) @(posedge clk_sys);
        `CHK("late", 3'b111, {fastAlarmOe, upperAlarmOe, lowerAlarmOe})
        `CHK("wires low", 3'h0, {fastAlarmIn, upperAlarmIn, lowerAlarmIn})
        {fastCmp, upperCmp, lowerCmp} <= 3'h0;
        repeat (6) @(posedge clk_sys);
        `CHK("released", 3'h0, {fastAlarmOe, upperAlarmOe, lowerAlarmOe})
        `CHK("drive level", 4'h0, {fastAlarmOut, upperAlarmOut, lowerAlarmOut, alertOut})
        apb(1'b1, ADDR_ALARM_CFG, 32'h27);
        repeat (2) @(posedge clk_sys);
        `CHK("latched", 1'b1, upperAlarmOe)
        apb(1'b1, ADDR_CMD, 32'h2);
        repeat (2) @(posedge clk_sys);
        `CHK("latch cleared", 1'b0, upperAlarmOe)
        apb(1'b1, ADDR_ALARM_CFG, 32'h7);
        $display("test alarms done");
    endtask : testAlarms
    // Alert enabled, unmasked, then disabled
    task automatic testAlert();
        apb(1'b1, ADDR_ALERT_MASK, 32'h82);
        upperCmp <= 1'b1;
        repeat (8) @(posedge clk_sys);
        `CHK("alert raised", 2'b10, {alertOe, alertIn})
        apb(1'b1, ADDR_ALERT_MASK, 32'h0);
        upperCmp <= 1'b0;
        repeat (6) @(posedge clk_sys);
        `CHK("alert off", 1'b0, alertOe)
        $display("test alert done");
    endtask : testAlert
    // Main sequence
    initial begin
        repeat (6) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        testResets();
        testTrigger();
        testCmd();
        testGpio();
        testAlarms();
        testAlert();
        conclude();
    end
endmodule : mta_side_pins_tb
